// *** hw/bus_if_regs.svh ***
// Widths and reset constants for the dual external bus block.
// Included by the bus top and the bench; definitions only.
`ifndef BUS_IF_REGS_SVH
`define BUS_IF_REGS_SVH

// Primary port widths
`define PRI_DATA_W 32
`define PRI_ADDR_W 24

// Expansion port widths
`define EXP_DATA_W 32
`define EXP_ADDR_W 13

// Core start address after reset; plain default, not a known part value
`define RESET_VECTOR_VAL 24'h000000

`endif

// *** hw/bus_if_pkg.sv ***
// Types shared by the access engine and the bus top.
// Assumes nothing beyond a SystemVerilog compiler.
package bus_if_pkg;

	typedef enum logic [1:0]
	{
		ACC_IDLE = 2'b01,
		ACC_ACTIVE = 2'b10
	} access_state_t;

	typedef enum logic [1:0]
	{
		BUS_OWNED = 2'b01,
		BUS_RELEASED = 2'b10
	} release_state_t;

endpackage

// *** hw/access_engine.sv ***
// One strobed external access sequencer with ready wait.
// Assumes ready is synchronous to ref_clk and float is a next-cycle value.
`timescale 1ns/1ps

module access_engine #(
	parameter int DATA_W = 32,
	parameter int ADDR_W = 24
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Core side
	input wire logic start,
	input wire logic write,
	input wire logic io_space,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata,
	output logic busy_q,
	output logic done_q,
	output logic [DATA_W-1:0] rdata_q,
	// Float control from the top
	input wire logic float_bus,
	input wire logic float_strobe,
	// Pin side
	output logic [ADDR_W-1:0] addr_q,
	output logic addr_oe_q,
	output logic read_not_write_q,
	output logic mem_strobe_n_q,
	output logic io_strobe_n_q,
	output logic strobe_oe_q,
	output logic [DATA_W-1:0] data_out_q,
	output logic data_oe_q,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic ready_n
);

	bus_if_pkg::access_state_t state_q;
	logic write_q;

	wire idle = (state_q == bus_if_pkg::ACC_IDLE);
	wire take = idle && start && !float_bus;
	// A floated bus ends the access so the core never hangs
	wire finish = !idle && (!ready_n || float_bus);
	wire drive_d = take ? write : (finish ? 1'b0 : (write_q && !idle));

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_q <= bus_if_pkg::ACC_IDLE;
			write_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			rdata_q <= '0;
			addr_q <= '0;
			read_not_write_q <= 1'b1;
			mem_strobe_n_q <= 1'b1;
			io_strobe_n_q <= 1'b1;
			data_out_q <= '0;
		end
		else
		begin
			done_q <= finish;
			if (take)
			begin
				state_q <= bus_if_pkg::ACC_ACTIVE;
				busy_q <= 1'b1;
				write_q <= write;
				addr_q <= addr_in;
				read_not_write_q <= !write;
				data_out_q <= wdata;
				mem_strobe_n_q <= io_space;
				io_strobe_n_q <= !io_space;
			end
			else if (finish)
			begin
				state_q <= bus_if_pkg::ACC_IDLE;
				busy_q <= 1'b0;
				if (!write_q && !ready_n)
					rdata_q <= data_in;
				read_not_write_q <= 1'b1;
				mem_strobe_n_q <= 1'b1;
				io_strobe_n_q <= 1'b1;
			end
		end
	end

	// Enables track the float request one edge later
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			addr_oe_q <= 1'b0;
			data_oe_q <= 1'b0;
		end
		else
		begin
			addr_oe_q <= !float_bus;
			data_oe_q <= !float_bus && drive_d;
		end
	end

	// strobes driven through reset
	// Reset does not float the strobes, so the far side sees them high
	always_ff @(posedge ref_clk)
	begin
		strobe_oe_q <= !float_strobe;
	end

	property p_strobe_wait;
		@(posedge ref_clk) disable iff (rst)
		(!mem_strobe_n_q && ready_n && !float_bus) |=> !mem_strobe_n_q;
	endproperty
	a_strobe_wait: assert property (p_strobe_wait) else $error("strobe dropped before ready");

	property p_one_strobe;
		@(posedge ref_clk) disable iff (rst)
		!(!mem_strobe_n_q && !io_strobe_n_q);
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("memory and io strobes both low");

	// data driven only for a live write
	property p_write_drive;
		@(posedge ref_clk) disable iff (rst)
		data_oe_q |-> (!read_not_write_q && (!mem_strobe_n_q || !io_strobe_n_q));
	endproperty
	a_write_drive: assert property (p_write_drive) else $error("data driven outside a write");

endmodule

// *** hw/dual_bus_if.sv ***
// Primary and expansion external bus logic with bus release handshake.
// Assumes all pin inputs are synchronous to ref_clk; tri-state resolved outside.
`timescale 1ns/1ps
`include "bus_if_regs.svh"

module dual_bus_if #(
	parameter logic [`PRI_ADDR_W-1:0] RESET_VECTOR = `RESET_VECTOR_VAL
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Core run state
	output logic core_run_q,
	output logic [`PRI_ADDR_W-1:0] core_start_addr_q,
	// Core primary requests
	input wire logic pri_req,
	input wire logic pri_write,
	input wire logic [`PRI_ADDR_W-1:0] pri_addr,
	input wire logic [`PRI_DATA_W-1:0] pri_wdata,
	output logic pri_busy,
	output logic pri_done,
	output logic [`PRI_DATA_W-1:0] pri_rdata,
	// Core expansion requests
	input wire logic exp_req,
	input wire logic exp_write,
	input wire logic exp_io,
	input wire logic [`EXP_ADDR_W-1:0] exp_addr,
	input wire logic [`EXP_DATA_W-1:0] exp_wdata,
	output logic exp_busy,
	output logic exp_done,
	output logic [`EXP_DATA_W-1:0] exp_rdata,
	// Control inputs
	input wire logic shutdown_float,
	input wire logic release_disable_bit,
	// Primary pins
	output logic [`PRI_ADDR_W-1:0] primary_address_bus,
	output logic primary_address_oe,
	output logic primary_read_not_write,
	output logic primary_access_strobe_n,
	output logic primary_strobe_oe,
	output logic [`PRI_DATA_W-1:0] primary_data_bus_out,
	output logic primary_data_bus_oe,
	input wire logic [`PRI_DATA_W-1:0] primary_data_bus_in,
	input wire logic primary_ready_n,
	// Release handshake pins
	input wire logic bus_release_req_n,
	output logic bus_release_ack_n,
	output logic bus_release_ack_oe,
	// Expansion pins
	output logic [`EXP_ADDR_W-1:0] expansion_address_bus,
	output logic expansion_address_oe,
	output logic expansion_read_not_write,
	output logic expansion_memory_strobe_n,
	output logic expansion_io_strobe_n,
	output logic expansion_strobe_oe,
	output logic [`EXP_DATA_W-1:0] expansion_data_bus_out,
	output logic expansion_data_bus_oe,
	input wire logic [`EXP_DATA_W-1:0] expansion_data_bus_in,
	input wire logic expansion_ready_in_n
);

	bus_if_pkg::release_state_t rel_q;

	wire hold_want = !bus_release_req_n && !release_disable_bit;
	// Grant only between accesses; an open access finishes first
	wire released_d = hold_want && ((rel_q == bus_if_pkg::BUS_RELEASED) || !pri_busy);
	wire pri_float = shutdown_float || released_d || rst;
	wire pri_strobe_float = shutdown_float || released_d;
	wire exp_float = shutdown_float || rst;

	// request high or disable gives high
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rel_q <= bus_if_pkg::BUS_OWNED;
			bus_release_ack_n <= 1'b1;
		end
		else
		begin
			rel_q <= released_d ? bus_if_pkg::BUS_RELEASED : bus_if_pkg::BUS_OWNED;
			bus_release_ack_n <= !released_d;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		bus_release_ack_oe <= !shutdown_float;
	end

	// core starts at vector after reset
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			core_run_q <= 1'b0;
			core_start_addr_q <= '0;
		end
		else
		begin
			core_run_q <= 1'b1;
			core_start_addr_q <= RESET_VECTOR;
		end
	end

	access_engine #(
		.DATA_W(`PRI_DATA_W),
		.ADDR_W(`PRI_ADDR_W)
	) u_primary (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(pri_req),
		.write(pri_write),
		.io_space(1'b0),
		.addr_in(pri_addr),
		.wdata(pri_wdata),
		.busy_q(pri_busy),
		.done_q(pri_done),
		.rdata_q(pri_rdata),
		.float_bus(pri_float),
		.float_strobe(pri_strobe_float),
		.addr_q(primary_address_bus),
		.addr_oe_q(primary_address_oe),
		.read_not_write_q(primary_read_not_write),
		.mem_strobe_n_q(primary_access_strobe_n),
		.io_strobe_n_q(),
		.strobe_oe_q(primary_strobe_oe),
		.data_out_q(primary_data_bus_out),
		.data_oe_q(primary_data_bus_oe),
		.data_in(primary_data_bus_in),
		.ready_n(primary_ready_n)
	);

	access_engine #(
		.DATA_W(`EXP_DATA_W),
		.ADDR_W(`EXP_ADDR_W)
	) u_expansion (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(exp_req),
		.write(exp_write),
		.io_space(exp_io),
		.addr_in(exp_addr),
		.wdata(exp_wdata),
		.busy_q(exp_busy),
		.done_q(exp_done),
		.rdata_q(exp_rdata),
		.float_bus(exp_float),
		.float_strobe(shutdown_float),
		.addr_q(expansion_address_bus),
		.addr_oe_q(expansion_address_oe),
		.read_not_write_q(expansion_read_not_write),
		.mem_strobe_n_q(expansion_memory_strobe_n),
		.io_strobe_n_q(expansion_io_strobe_n),
		.strobe_oe_q(expansion_strobe_oe),
		.data_out_q(expansion_data_bus_out),
		.data_oe_q(expansion_data_bus_oe),
		.data_in(expansion_data_bus_in),
		.ready_n(expansion_ready_in_n)
	);

	property p_ack_floated;
		@(posedge ref_clk) disable iff (rst)
		!bus_release_ack_n |-> (!primary_address_oe && !primary_data_bus_oe && !primary_strobe_oe);
	endproperty
	a_ack_floated: assert property (p_ack_floated) else $error("ack low while primary bus driven");

	property p_ack_high;
		@(posedge ref_clk) disable iff (rst)
		(bus_release_req_n || release_disable_bit) |=> bus_release_ack_n;
	endproperty
	a_ack_high: assert property (p_ack_high) else $error("ack low without active request");

	property p_grant_idle;
		@(posedge ref_clk) disable iff (rst)
		(!bus_release_req_n && !release_disable_bit && !pri_busy) |=> (!bus_release_ack_n && !pri_busy);
	endproperty
	a_grant_idle: assert property (p_grant_idle) else $error("idle bus not released");

	property p_strobe_quiet;
		@(posedge ref_clk) disable iff (rst)
		!bus_release_ack_n |-> primary_access_strobe_n;
	endproperty
	a_strobe_quiet: assert property (p_strobe_quiet) else $error("strobe low while released");

	property p_shutdown_float;
		@(posedge ref_clk) disable iff (rst)
		shutdown_float |=> (!primary_address_oe && !expansion_address_oe && !expansion_strobe_oe
			&& !bus_release_ack_oe);
	endproperty
	a_shutdown_float: assert property (p_shutdown_float) else $error("pins driven under shutdown");

	property p_pri_rw_steady;
		@(posedge ref_clk) disable iff (rst)
		(!primary_access_strobe_n && !$fell(primary_access_strobe_n)) |-> $stable(primary_read_not_write);
	endproperty
	a_pri_rw_steady: assert property (p_pri_rw_steady) else $error("primary read/write moved mid access");

	property p_exp_ready;
		@(posedge ref_clk) disable iff (rst || shutdown_float)
		$rose(exp_done) |-> !$past(expansion_ready_in_n);
	endproperty
	a_exp_ready: assert property (p_exp_ready) else $error("expansion done without ready");

	// run rises one edge after release
	property p_run_start;
		@(posedge ref_clk) disable iff (rst)
		$fell(rst) |-> (!core_run_q ##1 (core_run_q && core_start_addr_q == RESET_VECTOR));
	endproperty
	a_run_start: assert property (p_run_start) else $error("core did not start at vector");

	property p_exp_rw;
		@(posedge ref_clk) disable iff (rst)
		(exp_req && exp_write && !exp_busy && !shutdown_float) |=>
			(!expansion_read_not_write && (expansion_memory_strobe_n == $past(exp_io)));
	endproperty
	a_exp_rw: assert property (p_exp_rw) else $error("expansion write not framed");

endmodule

// *** verif/bus_target_model.sv ***
// Far-side memory or peripheral for one port of the external bus block.
// Assumes strobe and address are registered pins sampled on ref_clk.
`timescale 1ns/1ps

module bus_target_model #(
	parameter int ADDR_W = 24
) (
	// Clock
	input wire logic ref_clk,
	// Pins from the device, and the wait count set by the bench
	input wire logic strobe_n,
	input wire logic read_not_write,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [3:0] wait_cycles,
	// Pins back to the device
	output logic [31:0] data_in,
	output logic ready_n
);
	logic [3:0] cnt_q = 4'h0;
	logic [31:0] last_q = 32'h0;
	logic hit;
	assign hit = !strobe_n && cnt_q == wait_cycles;
	assign ready_n = !hit;
	// Undriven data shows a changing pattern, never stale
	assign data_in = (hit && read_not_write) ? (32'h5a000000 ^ 32'(addr)) : ~last_q;
	always_ff @(posedge ref_clk)
	begin
		cnt_q <= strobe_n ? 4'h0 : cnt_q + 4'h1;
		last_q <= data_in;
	end
endmodule

// *** verif/dual_bus_if_test.sv ***
// Self-checking bench for the dual external bus block.
// Assumes the far side is two bus_target_model instances.
`timescale 1ns/1ps
`include "bus_if_regs.svh"

module dual_bus_if_test;
	localparam logic [`PRI_ADDR_W-1:0] VEC = 24'h00a5c0;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic pri_req = 1'b0, pri_write = 1'b0, exp_req = 1'b0, exp_write = 1'b0, exp_io = 1'b0;
	logic shutdown_float = 1'b0, release_disable_bit = 1'b0, bus_release_req_n = 1'b1;
	logic primary_ready_n, expansion_ready_in_n, core_run_q, pri_busy, pri_done, exp_busy, exp_done;
	logic primary_address_oe, primary_read_not_write, primary_access_strobe_n, primary_strobe_oe;
	logic primary_data_bus_oe, bus_release_ack_n, bus_release_ack_oe, expansion_address_oe;
	logic expansion_read_not_write, expansion_memory_strobe_n, expansion_io_strobe_n;
	logic expansion_strobe_oe, expansion_data_bus_oe, exp_strobe_n;
	logic [`PRI_ADDR_W-1:0] core_start_addr_q, primary_address_bus, pri_addr = 24'h0;
	logic [`EXP_ADDR_W-1:0] expansion_address_bus, exp_addr = 13'h0;
	logic [31:0] pri_wdata = 32'h0, exp_wdata = 32'h0, pri_rdata, exp_rdata, lfsr = 32'd23;
	logic [31:0] primary_data_bus_out, primary_data_bus_in, expansion_data_bus_out, expansion_data_bus_in;
	logic [3:0] wait_cycles = 4'h0;
	int num_errors = 0;
	int comparisons = 0;

	dual_bus_if #(.RESET_VECTOR(VEC)) dual_bus_if_i (.*);
	assign exp_strobe_n = expansion_memory_strobe_n & expansion_io_strobe_n;
	bus_target_model #(.ADDR_W(24)) pri_bus_target_model_i (.ref_clk(ref_clk), .strobe_n(primary_access_strobe_n),
		.read_not_write(primary_read_not_write), .addr(primary_address_bus), .wait_cycles(wait_cycles),
		.data_in(primary_data_bus_in), .ready_n(primary_ready_n));
	bus_target_model #(.ADDR_W(13)) exp_bus_target_model_i (.ref_clk(ref_clk), .strobe_n(exp_strobe_n),
		.read_not_write(expansion_read_not_write), .addr(expansion_address_bus), .wait_cycles(wait_cycles),
		.data_in(expansion_data_bus_in), .ready_n(expansion_ready_in_n));

	always #5 ref_clk = ~ref_clk;

	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] exp_word(logic [23:0] a);
		return 32'h5a000000 ^ {8'h00, a};
	endfunction

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// One access on either port; a is already cut to the port width
	task automatic access(input bit pri, input bit wr, input bit io, input logic [23:0] a,
		input logic [31:0] d, input logic [3:0] w);
		int n;
		bit fin;
		logic s_n, rw, doe, dn;
		logic [31:0] ad, dout;
		n = 0;
		fin = 0;
		@(posedge ref_clk);
		wait_cycles <= w;
		pri_req <= pri;
		exp_req <= !pri;
		pri_write <= wr;
		exp_write <= wr;
		exp_io <= io;
		pri_addr <= a;
		exp_addr <= a[12:0];
		pri_wdata <= d;
		exp_wdata <= d;
		for (int i = 0; i < 24 && !fin; i++)
		begin
			@(posedge ref_clk);
			pri_req <= 1'b0;
			exp_req <= 1'b0;
			#1;
			s_n = pri ? primary_access_strobe_n : exp_strobe_n;
			rw = pri ? primary_read_not_write : expansion_read_not_write;
			doe = pri ? primary_data_bus_oe : expansion_data_bus_oe;
			dn = pri ? pri_done : exp_done;
			ad = pri ? 32'(primary_address_bus) : 32'(expansion_address_bus);
			dout = pri ? primary_data_bus_out : expansion_data_bus_out;
			if (s_n === 1'b0)
			begin
				n++;
				chk("addr", ad, a);
				chk("rw", rw, !wr);
				chk("data_oe", doe, wr);
				if (wr)
					chk("data_out", dout, d);
				if (!pri)
					chk("mem_io_strobe", {expansion_memory_strobe_n, expansion_io_strobe_n}, {io, !io});
			end
			if (dn === 1'b1)
			begin
				fin = 1;
				chk("strobe_idle", s_n, 1'b1);
			end
		end
		if (!fin)
		begin
			num_errors++;
			end_sim();
		end
		else
		begin
			chk("strobe_cycles", n, w + 1);
			if (!wr)
				chk("rdata", pri ? pri_rdata : exp_rdata, exp_word(a));
		end
	endtask

	initial
	begin
		cyc(1);
		#1;
		chk("run_in_rst", core_run_q, 1'b0);
		chk("rst_pins", {primary_address_oe, primary_data_bus_oe, expansion_address_oe, primary_access_strobe_n}, 1);
		chk("rst_strobe_oe", {primary_strobe_oe, expansion_strobe_oe, bus_release_ack_oe}, 7);
		@(posedge ref_clk);
		rst <= 1'b0;
		cyc(2);
		#1;
		chk("run", {core_run_q, core_start_addr_q}, {1'b1, VEC});
		access(1, 0, 0, 24'hffffff, 0, 0);
		access(0, 1, 1, 24'h001fff, 32'hffffffff, 0);
		for (int k = 0; k < 40; k++)
		begin
			lfsr = lfsr_next(lfsr);
			access(lfsr[0], lfsr[1], lfsr[2], lfsr[0] ? lfsr[31:8] : {11'h0, lfsr[20:8]}, ~lfsr, {2'b0, lfsr[4:3]});
		end
		// Bus release while idle, then blocked request, then disable
		@(posedge ref_clk);
		bus_release_req_n <= 1'b0;
		cyc(2);
		#1;
		chk("ack_n", bus_release_ack_n, 1'b0);
		chk("rel_pins", {primary_access_strobe_n, primary_address_oe, primary_strobe_oe, primary_data_bus_oe}, 8);
		@(posedge ref_clk);
		pri_req <= 1'b1;
		cyc(3);
		#1;
		chk("rel_busy", pri_busy, 1'b0);
		@(posedge ref_clk);
		pri_req <= 1'b0;
		release_disable_bit <= 1'b1;
		cyc(2);
		#1;
		chk("dis_ack", {bus_release_ack_n, primary_address_oe}, 3);
		@(posedge ref_clk);
		release_disable_bit <= 1'b0;
		bus_release_req_n <= 1'b1;
		cyc(2);
		#1;
		chk("req_hi_ack", bus_release_ack_n, 1'b1);
		// Release asked for in mid-access
		@(posedge ref_clk);
		wait_cycles <= 4'h5;
		pri_req <= 1'b1;
		pri_write <= 1'b1;
		@(posedge ref_clk);
		pri_req <= 1'b0;
		bus_release_req_n <= 1'b0;
		repeat (12)
		begin
			@(posedge ref_clk);
			#1;
			if (pri_busy === 1'b1)
				chk("open_ack", {bus_release_ack_n, primary_strobe_oe}, 3);
		end
		chk("late_ack", bus_release_ack_n, 1'b0);
		@(posedge ref_clk);
		bus_release_req_n <= 1'b1;
		shutdown_float <= 1'b1;
		cyc(2);
		#1;
		chk("shutdown_oe", {primary_address_oe, primary_strobe_oe, primary_data_bus_oe, bus_release_ack_oe,
			expansion_address_oe, expansion_strobe_oe, expansion_data_bus_oe}, 0);
		chk("shutdown_strobe", {primary_access_strobe_n, exp_strobe_n}, 3);
		@(posedge ref_clk);
		shutdown_float <= 1'b0;
		cyc(2);
		access(0, 0, 0, 24'h000123, 0, 2);
		@(posedge ref_clk);
		rst <= 1'b1;
		cyc(2);
		#1;
		chk("rst_again", {core_run_q, primary_address_oe, expansion_address_oe}, 0);
		end_sim();
	end
endmodule
